// [sim/pwg_fault_pins.sv]
module pwg_fault_pins
    import pwg_pkg::*;
(
    input wire logic [NFLT-1:0] assert_in, // inputs to assert
    input wire logic [NFLT-1:0] sense_low_in, // inputs asserted low
    output logic [NFLT-1:0] pins_out // pin levels
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle pins rest at the level opposite to their asserted sense
    assign pins_out = assert_in ^ sense_low_in;
endmodule

// [sim/pwg_fault_unit_props.sv]
module pwg_fault_unit_props
    import pwg_pkg::*;
(
    input wire logic clk_in, // clock
    input wire logic srst_in, // sync reset
    input wire logic hsel_in, // select
    input wire logic [1:0] htrans_in, // transfer type
    input wire logic hwrite_in, // write
    input wire logic hready_in, // bus ready
    input wire logic [31:0] hrdata_out, // read data
    input wire logic hreadyout_out, // slave ready
    input wire logic hresp_out, // response
    input wire logic [NFLT-1:0] fault_input_line_in, // fault pins
    input wire logic [NGEN-1:0] fault_active_out, // fault per gen
    input wire logic generator0_fault_irq_out, // gen 0 irq
    input wire logic generator1_fault_irq_out, // gen 1 irq
    input wire logic generator2_fault_irq_out, // gen 2 irq
    input wire logic generator3_fault_irq_out, // gen 3 irq
    input wire logic fault_irq_out // any irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------
    // bus phase tracking
    // ------
    logic rd_q;
    logic seen_q;
    wire take = hsel_in & htrans_in[HTRANS_ACTIVE_BIT] & hready_in;
    wire rd_d = take & ~hwrite_in;
    wire seen_d = seen_q | (take & hwrite_in);
    wire [NGEN-1:0] gen_irq = {generator3_fault_irq_out, generator2_fault_irq_out,
        generator1_fault_irq_out, generator0_fault_irq_out};
    wire any_irq = |gen_irq;
    always_ff @(posedge clk_in) begin
        rd_q <= srst_in ? 1'h0 : rd_d;
        seen_q <= srst_in ? 1'h0 : seen_d;
    end
    // ------
    // properties
    // ------
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    property p_ready; hreadyout_out == 1'h1; endproperty
    property p_okay; hresp_out == HRESP_OKAY; endproperty
    property p_rd_idle; !rd_q |-> hrdata_out == WORD_ZERO; endproperty
    property p_irq_any; any_irq |-> ##[0:1] fault_irq_out; endproperty
    property p_irq_src; fault_irq_out |-> any_irq || $past(any_irq); endproperty
    property p_irq_off; !seen_q |-> gen_irq == 4'h0; endproperty
    property p_flt_on;
        (!seen_q && fault_input_line_in[0]) [*5] |-> fault_active_out == 4'hf;
    endproperty
    property p_flt_off;
        (!seen_q && !fault_input_line_in[0]) [*5] |-> fault_active_out == 4'h0;
    endproperty
    a_ready: assert property (p_ready) else $error("slave not ready");
    a_okay: assert property (p_okay) else $error("response not okay");
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
    a_irq_any: assert property (p_irq_any) else $error("summary irq missing");
    a_irq_src: assert property (p_irq_src) else $error("summary irq stray");
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
    a_flt_on: assert property (p_flt_on) else $error("input 0 fault missed");
    a_flt_off: assert property (p_flt_off) else $error("fault without input");
    c_irq: cover property (fault_irq_out);
    c_stretch: cover property (fault_active_out[2] [*8]);
    c_read: cover property (rd_q && hrdata_out != WORD_ZERO);
endmodule

bind pwg_fault_unit pwg_fault_unit_props u_props (
    .clk_in(clk_in), .srst_in(srst_in), .hsel_in(hsel_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .fault_input_line_in(fault_input_line_in), .fault_active_out(fault_active_out),
    .generator0_fault_irq_out(generator0_fault_irq_out),
    .generator1_fault_irq_out(generator1_fault_irq_out),
    .generator2_fault_irq_out(generator2_fault_irq_out),
    .generator3_fault_irq_out(generator3_fault_irq_out), .fault_irq_out(fault_irq_out)
);

// [sim/pwm_generator_fault_control_bench.sv]
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("Error %0t: got %0h exp %0h", $time, (g), (e)); end end
module pwm_generator_fault_control_bench import pwg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic hsel = 1'h0;
    logic [AW-1:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = WORD_ZERO;
    logic halt = 1'h0;
    logic [NFLT-1:0] flt_on = FLT_NONE;
    logic [NFLT-1:0] flt_low = FLT_NONE;
    wire [31:0] hrdata;
    wire hready;
    wire [NFLT-1:0] pins;
    wire [NGEN-1:0] fact;
    wire [NGEN-1:0] irq;
    wire irq_any;
    int err_total = 0;
    int total_checks = 0;
    int hi_cnt = 0;
    logic [15:0] mx;
    logic [15:0] mn;
    pwg_fault_unit dut (
        .clk_in(clk), .srst_in(srst), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
        .fault_input_line_in(pins), .debug_halt_in(halt), .fault_active_out(fact),
        .generator0_fault_irq_out(irq[0]), .generator1_fault_irq_out(irq[1]),
        .generator2_fault_irq_out(irq[2]), .generator3_fault_irq_out(irq[3]),
        .fault_irq_out(irq_any)
    );
    pwg_fault_pins u_pins (.assert_in(flt_on), .sense_low_in(flt_low), .pins_out(pins));
    initial forever #25 clk = ~clk;
    always @(posedge clk) if (fact[2] === 1'h1) hi_cnt++;
    // ------
    // bus access
    // ------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [AW-1:0] ga(input int g, input logic [PAGE_LSB-1:0] o);
        return AW'(64 * (g + 1)) | AW'(o);
    endfunction
    task automatic aph(input logic [AW-1:0] a, input logic w);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        aph(a, 1'h1);
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'h1);
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [31:0] d);
        aph(a, 1'h0);
        do @(posedge clk); while (hready !== 1'h1);
        d = hrdata;
    endtask
    task automatic rchk(input logic [AW-1:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        `CHK(v, e)
    endtask
    // spacing of five cycles visits every phase of the short periods used
    task automatic sweep;
        logic [31:0] v;
        mx = CNT_ZERO;
        mn = 16'hffff;
        repeat (12) begin
            rd(ga(0, GOFS_CNT), v);
            if (v[15:0] > mx) mx = v[15:0];
            if (v[15:0] < mn) mn = v[15:0];
            cyc(3);
        end
    endtask
    task automatic hold_chk;
        logic [31:0] a;
        logic [31:0] b;
        rd(ga(0, GOFS_CNT), a);
        cyc(3);
        rd(ga(0, GOFS_CNT), b);
        `CHK(b, a)
    endtask
    // ------
    // scenarios
    // ------
    task automatic t_faults;
        int h0;
        rchk(ga(0, GOFS_FSRC), 32'h0000_0001);
        rchk(ga(3, GOFS_CFG), WORD_ZERO);
        flt_on <= 4'h1;
        cyc(6);
        `CHK(fact, 4'hf)
        rchk(OFS_INTSTS, 32'h0000_000f);
        wr(OFS_INTEN, 32'h0000_0001);
        cyc(5);
        `CHK({irq_any, irq}, 5'h11)
        wr(OFS_INTEN, WORD_ZERO);
        cyc(3);
        `CHK(irq_any, 1'h0)
        flt_on <= FLT_NONE;
        cyc(6);
        `CHK(fact, 4'h0)
        wr(OFS_INTSTS, 32'h0000_000f);
        rchk(OFS_INTSTS, WORD_ZERO);
        flt_low <= 4'h4;
        wr(ga(1, GOFS_CFG), 32'h0000_0280);
        wr(ga(1, GOFS_FSEN), 32'h0000_0004);
        wr(ga(1, GOFS_FSRC), 32'h0000_0006);
        cyc(4);
        `CHK(fact[1], 1'h0)
        flt_on <= 4'h4;
        cyc(3);
        flt_on <= FLT_NONE;
        cyc(6);
        `CHK(fact[1], 1'h1)
        rchk(ga(1, GOFS_FSTAT), 32'h0000_0004);
        rchk(OFS_INTSTS, 32'h0000_0002);
        wr(ga(1, GOFS_FSTAT), 32'h0000_0002);
        rchk(ga(1, GOFS_FSTAT), 32'h0000_0004);
        wr(ga(1, GOFS_FSTAT), 32'h0000_0004);
        cyc(3);
        rchk(ga(1, GOFS_FSTAT), WORD_ZERO);
        wr(OFS_INTSTS, 32'h0000_0002);
        cyc(3);
        rchk(OFS_INTSTS, WORD_ZERO);
        wr(ga(2, GOFS_CFG), 32'h0000_0300);
        wr(ga(2, GOFS_MINF), 32'h0000_0014);
        wr(OFS_INTEN, 32'h0000_0004);
        h0 = hi_cnt;
        flt_on <= 4'h1;
        cyc(2);
        flt_on <= FLT_NONE;
        cyc(6);
        wr(OFS_INTSTS, 32'h0000_0004);
        cyc(2);
        `CHK(irq[2], 1'h1)
        cyc(30);
        `CHK((hi_cnt - h0 >= 20) && (hi_cnt - h0 <= 21), 1'h1)
        wr(OFS_INTSTS, 32'h0000_000f);
        cyc(3);
        `CHK(irq[2], 1'h0)
    endtask
    task automatic t_count;
        logic [31:0] v;
        wr(ga(0, GOFS_CFG), WORD_ZERO);
        wr(ga(0, GOFS_LOAD), 32'h0000_0006);
        wr(ga(0, GOFS_EN), 32'h0000_0001);
        sweep();
        `CHK({mx, mn}, 32'h0006_0000)
        wr(ga(0, GOFS_CFG), 32'h0000_0001);
        hold_chk();
        wr(ga(0, GOFS_EN), 32'h0000_0001);
        rd(ga(0, GOFS_ACT), v);
        `CHK(v[0], 1'h1)
        sweep();
        `CHK({mx, mn}, 32'h0006_0000)
        wr(ga(0, GOFS_EN), WORD_ZERO);
        hold_chk();
        wr(ga(0, GOFS_CFG), 32'h0000_0002);
        wr(ga(0, GOFS_EN), 32'h0000_0001);
        wr(ga(0, GOFS_LOAD), 32'h0000_0003);
        sweep();
        `CHK(mx, 16'h0006)
        wr(OFS_GSYNC, 32'h0000_0001);
        cyc(10);
        sweep();
        `CHK({mx, mn}, 32'h0003_0000)
        wr(ga(0, GOFS_CFG), WORD_ZERO);
        wr(ga(0, GOFS_EN), 32'h0000_0001);
        halt <= 1'h1;
        cyc(12);
        sweep();
        `CHK({mx, mn}, 32'h0000_0000)
        wr(ga(0, GOFS_CFG), 32'h0000_0004);
        wr(ga(0, GOFS_EN), 32'h0000_0001);
        sweep();
        `CHK({mx, mn}, 32'h0003_0000)
        halt <= 1'h0;
    endtask
    // mode change waits for zero plus global sync, dead-band for zero only
    task automatic t_sync;
        logic [31:0] v;
        wr(ga(3, GOFS_CFG), 32'h0000_0031);
        wr(ga(3, GOFS_DB), 32'h0000_0123);
        wr(OFS_GSYNC, 32'h0000_0008);
        cyc(2);
        rd(ga(3, GOFS_ACT), v);
        `CHK({v[27:16], v[2], v[0]}, 14'h0002)
        rchk(ga(3, GOFS_DB), 32'h0000_0123);
        wr(ga(3, GOFS_EN), 32'h0000_0001);
        cyc(2);
        rd(ga(3, GOFS_ACT), v);
        `CHK({v[27:16], v[2], v[0]}, 14'h048d)
    endtask
    task automatic stop_test;
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'h0;
        cyc(2);
        t_faults();
        t_count();
        t_sync();
        stop_test();
    end
    initial begin
        #200us;
        err_total++;
        stop_test();
    end
endmodule

// [verilog/pwg_fault_unit.sv]
// What this block does
// - write-one clears fault interrupt status bit
// - extended: irq is OR of selected triggers
// - four fault interrupts, one per generator
// - legacy: irq follows fault input 0
// - module enable gates irq to controller
// - config write sets modes, disables counter
// - down mode: load down to zero, reload
// - up/down mode: zero to load, back
// - deferred: hold values until sync event
// - immediate: no wait for sync event
// - values transfer only at counter zero
// - halt pause: run to zero, then wait
// - keep running: debug halt ignored
// - mode change: immediate, local or global
// - dead-band: immediate, local or global
// - latched option keeps triggers after deassert
// - selected latched triggers cleared by write
// - minimum fault period stretches fault signal
// - irq held while minimum period runs
// - extended or legacy fault source option
// - enable bit gates clock to counter
// - minimum period counted in clock cycles
// - per-input high or low assert sense
// - default source is fault input 0
// - 16-bit down and up/down counter
//
// Design decisions made here: the AHB-Lite slave port and the register offsets.
module pwg_fault_unit
    import pwg_pkg::*;
(
    input wire logic clk_in,                 // 20 MHz clock
    input wire logic srst_in,                // sync reset, high
    input wire logic hsel_in,                // ahb slave select
    input wire logic [AW-1:0] haddr_in,      // ahb byte address
    input wire logic [1:0] htrans_in,        // ahb transfer type
    input wire logic hwrite_in,              // ahb write
    input wire logic [2:0] hsize_in,         // ahb size, word only
    input wire logic [31:0] hwdata_in,       // ahb write data
    input wire logic hready_in,              // ahb bus ready
    output logic [31:0] hrdata_out,          // ahb read data
    output logic hreadyout_out,              // ahb slave ready
    output logic hresp_out,                  // ahb response
    input wire logic [NFLT-1:0] fault_input_line_in, // fault pins
    input wire logic debug_halt_in,          // processor halted
    output logic [NGEN-1:0] fault_active_out, // fault to power stage
    output logic generator0_fault_irq_out,   // gen 0 masked irq
    output logic generator1_fault_irq_out,   // gen 1 masked irq
    output logic generator2_fault_irq_out,   // gen 2 masked irq
    output logic generator3_fault_irq_out,   // gen 3 masked irq
    output logic fault_irq_out               // any enabled fault irq
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic page_is(input logic [PAGE_W-1:0] page, input int g);
        return page == PAGE_W'(g + 1);
    endfunction

    function automatic logic upd_ok(input logic [1:0] sel, input logic zero,
                                    input logic sync);
        logic ok;
        ok = 1'b1;
        unique case (sel)
            UPD_IMMED: ok = 1'b1;
            UPD_LOCAL: ok = zero;
            UPD_GLOBAL: ok = zero & sync;
            default: ok = 1'b1;
        endcase
        return ok;
    endfunction

    // ----------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ----------------------------------------------------------------
    logic wr_q;
    logic [AW-1:0] waddr_q;
    logic [31:0] hrdata_q;
    logic hready_q;
    logic [31:0] rd_word;
    logic [31:0] gen_rd [NGEN];

    wire addr_ok = hsel_in & htrans_in[HTRANS_ACTIVE_BIT] & hready_in;
    wire wr_req = addr_ok & hwrite_in;
    wire rd_req = addr_ok & ~hwrite_in;
    wire [PAGE_W-1:0] rpage = haddr_in[AW-1:PAGE_LSB];
    wire rpage_ok = (rpage != '0) && (rpage <= PAGE_W'(NGEN));
    wire [1:0] ridx = 2'(rpage - PAGE_W'(1));
    wire [PAGE_LSB-1:0] wofs = waddr_q[PAGE_LSB-1:0];
    wire [PAGE_W-1:0] wpage = waddr_q[AW-1:PAGE_LSB];
    wire unused_size = ^hsize_in;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_q <= 1'b0;
            waddr_q <= '0;
            hrdata_q <= WORD_ZERO;
            hready_q <= 1'b1;
        end else begin
            wr_q <= wr_req;
            waddr_q <= haddr_in;
            hrdata_q <= rd_req ? rd_word : WORD_ZERO;
            hready_q <= 1'b1;
        end
    end

    assign hrdata_out = hrdata_q;
    assign hreadyout_out = hready_q;
    assign hresp_out = HRESP_OKAY | (unused_size & 1'b0);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [NFLT-1:0] fin_m_q;
    logic [NFLT-1:0] fin_s_q;
    logic halt_m_q;
    logic halt_s_q;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            fin_m_q <= FLT_NONE;
            fin_s_q <= FLT_NONE;
            halt_m_q <= 1'b0;
            halt_s_q <= 1'b0;
        end else begin
            fin_m_q <= fault_input_line_in;
            fin_s_q <= fin_m_q;
            halt_m_q <= debug_halt_in;
            halt_s_q <= halt_m_q;
        end
    end

    // ----------------------------------------------------------------
    // module-level fault interrupt status and enable
    // ----------------------------------------------------------------
    logic [NGEN-1:0] inten_q;
    logic [NGEN-1:0] sts_q;
    logic [NGEN-1:0] irq_q;
    logic irq_any_q;
    logic [NGEN-1:0] fact_q;
    wire [NGEN-1:0] fault_sig;

    wire gsync_wr = wr_q && (waddr_q == OFS_GSYNC);
    wire inten_wr = wr_q && (waddr_q == OFS_INTEN);
    wire sts_wr = wr_q && (waddr_q == OFS_INTSTS);
    wire [NGEN-1:0] sts_clr = sts_wr ? hwdata_in[NGEN-1:0] : '0;
    // set wins over a same-cycle clear
    wire [NGEN-1:0] sts_d = fault_sig | (sts_q & ~sts_clr);
    wire [NGEN-1:0] irq_d = sts_q & inten_q;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            inten_q <= '0;
            sts_q <= '0;
            irq_q <= '0;
            irq_any_q <= 1'b0;
            fact_q <= '0;
        end else begin
            if (inten_wr) begin
                inten_q <= hwdata_in[NGEN-1:0];
            end
            sts_q <= sts_d;
            irq_q <= irq_d;
            irq_any_q <= |irq_d;
            fact_q <= fault_sig;
        end
    end

    assign generator0_fault_irq_out = irq_q[0];
    assign generator1_fault_irq_out = irq_q[1];
    assign generator2_fault_irq_out = irq_q[2];
    assign generator3_fault_irq_out = irq_q[3];
    assign fault_irq_out = irq_any_q;
    assign fault_active_out = fact_q;

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    assign rd_word = (haddr_in == OFS_INTEN) ? 32'(inten_q) :
                     (haddr_in == OFS_INTSTS) ? 32'(sts_q) :
                     rpage_ok ? gen_rd[ridx] : WORD_ZERO;

    // ----------------------------------------------------------------
    // generators
    // ----------------------------------------------------------------
    for (genvar g = 0; g < NGEN; g++) begin : gen_slice
        pwg_cfg_t cfg_q;
        logic en_q;
        logic [CNT_W-1:0] load_pend_q;
        logic [CNT_W-1:0] load_q;
        logic [CNT_W-1:0] cmp_pend_q;
        logic [CNT_W-1:0] cmp_q;
        logic [CNT_W-1:0] cnt_q;
        pwg_dir_t dir_q;
        logic updown_q;
        logic [DB_W-1:0] db_pend_q;
        logic [DB_W-1:0] db_q;
        logic sync_q;
        logic [NFLT-1:0] src_q;
        logic [CNT_W-1:0] min_q;
        logic [NFLT-1:0] sense_q;
        logic [NFLT-1:0] latch_q;
        logic raw_q;
        logic [CNT_W-1:0] mcnt_q;

        wire wsel = wr_q && page_is(wpage, g);
        wire cfg_wr = wsel && (wofs == GOFS_CFG);
        wire en_wr = wsel && (wofs == GOFS_EN);
        wire load_wr = wsel && (wofs == GOFS_LOAD);
        wire cmp_wr = wsel && (wofs == GOFS_CMP);
        wire fsrc_wr = wsel && (wofs == GOFS_FSRC);
        wire minf_wr = wsel && (wofs == GOFS_MINF);
        wire fsen_wr = wsel && (wofs == GOFS_FSEN);
        wire fstat_wr = wsel && (wofs == GOFS_FSTAT);
        wire db_wr = wsel && (wofs == GOFS_DB);

        // counter timing
        wire halt_stop = halt_s_q && !cfg_q.keep_run && (cnt_q == CNT_ZERO);
        wire run = en_q && !halt_stop;
        wire at_zero = run && (cnt_q == CNT_ZERO);
        wire par_apply = at_zero && (!cfg_q.deferred || sync_q);
        wire [CNT_W-1:0] load_nx = par_apply ? load_pend_q : load_q;
        wire mode_apply = upd_ok(cfg_q.mode_upd, at_zero, sync_q);
        wire db_apply = upd_ok(cfg_q.db_upd, at_zero, sync_q);
        wire top = cnt_q >= load_q;
        wire bottom = cnt_q == CNT_ZERO;
        wire [CNT_W-1:0] cnt_dec = bottom ? CNT_ZERO : cnt_q - CNT_ONE;
        wire [CNT_W-1:0] cnt_inc = cnt_q + CNT_ONE;
        wire [CNT_W-1:0] cnt_down = bottom ? load_nx : cnt_dec;
        wire [CNT_W-1:0] cnt_ud_up = top ? cnt_dec : cnt_inc;
        wire [CNT_W-1:0] cnt_ud_dn = bottom ? ((load_nx == CNT_ZERO) ? CNT_ZERO : CNT_ONE)
                                            : cnt_dec;
        wire [CNT_W-1:0] cnt_ud = (dir_q == DIR_UP) ? cnt_ud_up : cnt_ud_dn;
        wire [CNT_W-1:0] cnt_d = !run ? cnt_q : (updown_q ? cnt_ud : cnt_down);
        wire dir_flip = ((dir_q == DIR_UP) && top) || ((dir_q == DIR_DOWN) && bottom);
        wire pwg_dir_t dir_d = (!run || !updown_q) ? (updown_q ? dir_q : DIR_UP) :
                               (dir_flip ? pwg_dir_t'(~dir_q) : dir_q);

        // fault path
        wire [NFLT-1:0] asserted = fin_s_q ^ sense_q;
        wire [NFLT-1:0] src_use = cfg_q.extended ? src_q : FLT_SRC_LEGACY;
        wire [NFLT-1:0] trig = asserted & src_use;
        wire [NFLT-1:0] lclr = fstat_wr ? hwdata_in[NFLT-1:0] : FLT_NONE;
        wire [NFLT-1:0] latch_d = cfg_q.latched ? ((latch_q & ~lclr) | trig) : FLT_NONE;
        wire [NFLT-1:0] stat = cfg_q.latched ? (latch_q | trig) : trig;
        wire raw = |stat;
        wire rise = raw && !raw_q;
        wire [CNT_W-1:0] mload = (min_q == CNT_ZERO) ? CNT_ZERO : min_q - CNT_ONE;
        wire mrun = mcnt_q != CNT_ZERO;
        wire [CNT_W-1:0] mcnt_d = !cfg_q.minper ? CNT_ZERO :
                                  rise ? mload :
                                  mrun ? mcnt_q - CNT_ONE : CNT_ZERO;
        assign fault_sig[g] = raw || mrun;

        always_ff @(posedge clk_in) begin
            if (srst_in) begin
                cfg_q <= CFG_RST;
                en_q <= 1'b0;
                load_pend_q <= CNT_ZERO;
                load_q <= CNT_ZERO;
                cmp_pend_q <= CNT_ZERO;
                cmp_q <= CNT_ZERO;
                cnt_q <= CNT_ZERO;
                dir_q <= DIR_UP;
                updown_q <= 1'b0;
                db_pend_q <= DB_RST;
                db_q <= DB_RST;
                sync_q <= 1'b0;
                src_q <= FLT_SRC_LEGACY;
                min_q <= CNT_ZERO;
                sense_q <= FLT_NONE;
                latch_q <= FLT_NONE;
                raw_q <= 1'b0;
                mcnt_q <= CNT_ZERO;
            end else begin
                if (cfg_wr) begin
                    cfg_q <= pwg_cfg_t'(hwdata_in[CFG_W-1:0]);
                end
                en_q <= cfg_wr ? 1'b0 : (en_wr ? hwdata_in[0] : en_q);
                load_pend_q <= load_wr ? hwdata_in[CNT_W-1:0] : load_pend_q;
                cmp_pend_q <= cmp_wr ? hwdata_in[CNT_W-1:0] : cmp_pend_q;
                load_q <= load_nx;
                cmp_q <= par_apply ? cmp_pend_q : cmp_q;
                cnt_q <= cnt_d;
                dir_q <= dir_d;
                updown_q <= mode_apply ? cfg_q.updown : updown_q;
                db_pend_q <= db_wr ? hwdata_in[DB_W-1:0] : db_pend_q;
                db_q <= db_apply ? db_pend_q : db_q;
                // global sync request set wins over its consumption at zero
                sync_q <= (gsync_wr && hwdata_in[g]) || (sync_q && !at_zero);
                src_q <= fsrc_wr ? hwdata_in[NFLT-1:0] : src_q;
                min_q <= minf_wr ? hwdata_in[CNT_W-1:0] : min_q;
                sense_q <= fsen_wr ? hwdata_in[NFLT-1:0] : sense_q;
                latch_q <= latch_d;
                raw_q <= raw;
                mcnt_q <= mcnt_d;
            end
        end

        wire [PAGE_LSB-1:0] rofs = haddr_in[PAGE_LSB-1:0];
        wire [31:0] act_word = {4'h0, db_q, 12'h000, fault_sig[g], sync_q, dir_q, updown_q};
        assign gen_rd[g] = (rofs == GOFS_CFG) ? 32'(cfg_q) :
                           (rofs == GOFS_EN) ? 32'(en_q) :
                           (rofs == GOFS_LOAD) ? 32'(load_pend_q) :
                           (rofs == GOFS_CMP) ? 32'(cmp_pend_q) :
                           (rofs == GOFS_CNT) ? {cmp_q, cnt_q} :
                           (rofs == GOFS_FSRC) ? 32'(src_q) :
                           (rofs == GOFS_MINF) ? 32'(min_q) :
                           (rofs == GOFS_FSEN) ? 32'(sense_q) :
                           (rofs == GOFS_FSTAT) ? 32'(stat) :
                           (rofs == GOFS_DB) ? 32'(db_pend_q) :
                           (rofs == GOFS_ACT) ? act_word : WORD_ZERO;
    end

endmodule

// [verilog/pwg_pkg.sv]
package pwg_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NGEN = 4;
    localparam int NFLT = 4;
    localparam int CNT_W = 16;
    localparam int DB_W = 12;
    localparam int AW = 12;
    localparam int PAGE_LSB = 6;
    localparam int PAGE_W = AW - PAGE_LSB;
    localparam int HTRANS_ACTIVE_BIT = 1;

    // ----------------------------------------------------------------
    // module-level register byte offsets
    // ----------------------------------------------------------------
    localparam logic [AW-1:0] OFS_GSYNC = 12'h000;
    localparam logic [AW-1:0] OFS_INTEN = 12'h004;
    localparam logic [AW-1:0] OFS_INTSTS = 12'h008;

    // ----------------------------------------------------------------
    // per-generator offsets inside page g+1 (page = 0x40 bytes)
    // ----------------------------------------------------------------
    localparam logic [PAGE_LSB-1:0] GOFS_CFG = 6'h00;
    localparam logic [PAGE_LSB-1:0] GOFS_EN = 6'h04;
    localparam logic [PAGE_LSB-1:0] GOFS_LOAD = 6'h08;
    localparam logic [PAGE_LSB-1:0] GOFS_CMP = 6'h0c;
    localparam logic [PAGE_LSB-1:0] GOFS_CNT = 6'h10;
    localparam logic [PAGE_LSB-1:0] GOFS_FSRC = 6'h14;
    localparam logic [PAGE_LSB-1:0] GOFS_MINF = 6'h18;
    localparam logic [PAGE_LSB-1:0] GOFS_FSEN = 6'h1c;
    localparam logic [PAGE_LSB-1:0] GOFS_FSTAT = 6'h20;
    localparam logic [PAGE_LSB-1:0] GOFS_DB = 6'h24;
    localparam logic [PAGE_LSB-1:0] GOFS_ACT = 6'h28;

    // ----------------------------------------------------------------
    // field layouts and reset values
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        UPD_IMMED = 2'b00,
        UPD_LOCAL = 2'b01,
        UPD_GLOBAL = 2'b10
    } pwg_upd_t;

    typedef enum logic {
        DIR_DOWN = 1'b0,
        DIR_UP = 1'b1
    } pwg_dir_t;

    typedef struct packed {
        logic extended;
        logic minper;
        logic latched;
        logic [1:0] db_upd;
        logic [1:0] mode_upd;
        logic keep_run;
        logic deferred;
        logic updown;
    } pwg_cfg_t;

    localparam int CFG_W = 10;
    localparam pwg_cfg_t CFG_RST = 10'h000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [DB_W-1:0] DB_RST = 12'h000;
    localparam logic [NFLT-1:0] FLT_NONE = 4'h0;
    localparam logic [NFLT-1:0] FLT_SRC_LEGACY = 4'h1;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic HRESP_OKAY = 1'b0;

endpackage
